//--- hdl/dbn_top.sv
// Design decisions made here: the placing of the registers and register access over APB.
`default_nettype none
module dbn_top (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Received beacon
  input  wire logic               bcn_start,
  input  wire logic [15:0]        bcn_src,
  input  wire logic [7:0]         bcn_slot,
  input  wire logic               elem_valid,
  input  wire dbn_pkg::dbn_kind_t elem_kind,
  input  wire logic [15:0]        elem_target,
  input  wire logic               elem_status,
  input  wire logic [31:0]        elem_mas,
  input  wire logic               bcn_end,
  // Received command frame
  input  wire logic               cf_valid,
  input  wire logic [15:0]        cf_src,
  input  wire logic [15:0]        cf_dest,
  input  wire logic [7:0]         cf_len,
  // Command frame notification
  output logic                    cfn_valid,
  output logic [15:0]             cfn_src,
  output logic [7:0]              cfn_len,
  // Reservation notification
  output logic                    ntf_event,
  output logic                    ntf_busy,
  // Own beacon DRP block
  input  wire logic               bcn_tx_start,
  input  wire logic               bcn_tx_done,
  input  wire logic [1:0]         tx_rd_idx,
  output logic [2:0]              tx_count,
  output logic [15:0]             tx_rd_tgt,
  output logic                    tx_rd_status,
  output logic [31:0]             tx_rd_mas,
  output logic                    result_event_block_valid
);
  import dbn_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [1:0]  ctrl_reg;
  logic [15:0] dev_reg;
  logic [15:0] mc_reg;
  logic [1:0]  nidx_reg;
  logic [1:0]  tidx_reg;
  logic [16:0] txs_m [ELEM_N];
  logic [31:0] txs_s [ELEM_N];
  logic [2:0]  tstage_reg;
  logic [16:0] txa_m [ELEM_N];
  logic [31:0] txa_s [ELEM_N];
  logic [2:0]  tx_cnt_reg;
  logic        tx_pend_reg;
  logic        tx_sent_reg;
  logic        done_reg;
  logic        ovf_reg;
  logic [18:0] rxm [ELEM_N];
  logic [31:0] rxs [ELEM_N];
  logic [18:0] cfm [ELEM_N];
  logic [31:0] cfs [ELEM_N];
  logic [2:0]  rx_cnt;
  logic [2:0]  cf_cnt;
  logic        rx_any;
  logic        me_any;
  logic        term_reg;
  logic [15:0] src_reg;
  logic [7:0]  slot_reg;
  logic        nv_reg;
  logic        sel_conf;
  logic [7:0]  rsn_reg;
  logic [2:0]  len_reg;
  logic [15:0] nb_addr [NB_N];
  logic        nb_used [NB_N];
  logic        nb_me [NB_N];
  logic [2:0]  nb_rr;
  dbn_state_t  state;
  logic        nb_hit;
  logic [2:0]  nb_idx;
  logic        nb_free_ok;
  logic [2:0]  nb_free;
  logic [31:0] own_mask;
  logic        c_me;
  logic        c_kdrp;
  logic        c_keep;
  logic        c_conf;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_en;
  logic        ack_wr;
  logic        commit;
  logic        drop;
  logic        cf_hit;
  logic [18:0] elem_meta;

  assign wr_en = psel && penable && pready && pwrite;
  assign ack_wr = wr_en && (paddr == A_NACK) && pwdata[NACK_BIT];
  assign commit = wr_en && (paddr == A_TCMD) && pwdata[TCMD_COMMIT];
  assign elem_meta = {elem_kind, elem_status, elem_target};
  assign drop = (bcn_start && (state != ST_IDLE)) ||
                ((state == ST_RECV) && elem_valid &&
                 ((c_keep && (rx_cnt == ELEM_CNT)) || (c_conf && (cf_cnt == ELEM_CNT))));
  assign ntf_busy = nv_reg;

  // ----------------------------------------------------------------
  // Element classification
  // ----------------------------------------------------------------
  dbn_elem_class u_class (
    .kind     (elem_kind),
    .target   (elem_target),
    .mas      (elem_mas),
    .own_addr (dev_reg),
    .mc_addr  (mc_reg),
    .mc_en    (ctrl_reg[CTRL_MC]),
    .own_mask (own_mask),
    .to_me    (c_me),
    .keep_drp (c_kdrp),
    .keep_rx  (c_keep),
    .conflict (c_conf)
  );

  always_comb
  begin
    own_mask = 32'h0;
    for (int i = 0; i < ELEM_N; i++)
    begin
      if (3'(i) < tx_cnt_reg)
        own_mask = own_mask | txa_s[i];
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data = 32'h0;
    rd_ok = 1'b1;
    unique case (paddr)
      A_CTRL:  rd_data = 32'(ctrl_reg);
      A_DEV:   rd_data = 32'(dev_reg);
      A_MCAST: rd_data = 32'(mc_reg);
      A_NSTAT: rd_data = {8'h0, slot_reg, nv_reg, 4'h0, len_reg, rsn_reg};
      A_NSRC:  rd_data = 32'(src_reg);
      A_NIDX:  rd_data = 32'(nidx_reg);
      A_NTGT:  rd_data = 32'(sel_conf ? cfm[nidx_reg] : rxm[nidx_reg]);
      A_NMAS:  rd_data = sel_conf ? cfs[nidx_reg] : rxs[nidx_reg];
      A_NACK:  rd_data = 32'h0;
      A_TIDX:  rd_data = 32'(tidx_reg);
      A_TTGT:  rd_data = 32'(txs_m[tidx_reg]);
      A_TMAS:  rd_data = txs_s[tidx_reg];
      A_TCMD:  rd_data = {23'h0, tx_pend_reg, 1'b0, tx_cnt_reg, 1'b0, tstage_reg};
      A_STAT:  rd_data = {30'h0, done_reg, ovf_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !rd_ok;
      if (psel && penable && !pready)
        prdata <= rd_ok ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_reg <= CTRL_RST;
      dev_reg <= ADDR_RST;
      mc_reg <= ADDR_RST;
      nidx_reg <= 2'h0;
      tidx_reg <= 2'h0;
      tstage_reg <= 3'h0;
      for (int i = 0; i < ELEM_N; i++)
      begin
        txs_m[i] <= 17'h0;
        txs_s[i] <= 32'h0;
      end
    end
    else if (wr_en)
    begin
      unique case (paddr)
        A_CTRL:  ctrl_reg <= pwdata[1:0];
        A_DEV:   dev_reg <= pwdata[15:0];
        A_MCAST: mc_reg <= pwdata[15:0];
        A_NIDX:  nidx_reg <= pwdata[1:0];
        A_TIDX:  tidx_reg <= pwdata[1:0];
        A_TTGT:  txs_m[tidx_reg] <= pwdata[16:0];
        A_TMAS:  txs_s[tidx_reg] <= pwdata;
        A_TCMD:  tstage_reg <= (pwdata[2:0] > ELEM_CNT) ? ELEM_CNT : pwdata[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Beacon inspection and notification
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      rx_cnt <= 3'h0;
      cf_cnt <= 3'h0;
      rx_any <= 1'b0;
      me_any <= 1'b0;
      term_reg <= 1'b0;
      src_reg <= 16'h0;
      slot_reg <= 8'h0;
      nv_reg <= 1'b0;
      sel_conf <= 1'b0;
      rsn_reg <= RSN_RX;
      len_reg <= 3'h0;
      ntf_event <= 1'b0;
      for (int i = 0; i < ELEM_N; i++)
      begin
        rxm[i] <= 19'h0;
        rxs[i] <= 32'h0;
        cfm[i] <= 19'h0;
        cfs[i] <= 32'h0;
      end
    end
    else
    begin
      ntf_event <= 1'b0;
      unique case (state)
        ST_IDLE:
          if (bcn_start)
          begin
            src_reg <= bcn_src;
            slot_reg <= bcn_slot;
            rx_cnt <= 3'h0;
            cf_cnt <= 3'h0;
            rx_any <= 1'b0;
            me_any <= 1'b0;
            state <= ST_RECV;
          end
        ST_RECV:
        begin
          if (elem_valid)
          begin
            if (c_keep && (rx_cnt < ELEM_CNT))
            begin
              rxm[rx_cnt[1:0]] <= elem_meta;
              rxs[rx_cnt[1:0]] <= elem_mas;
              rx_cnt <= rx_cnt + 3'h1;
            end
            if (c_kdrp)
              rx_any <= 1'b1;
            if (c_me)
              me_any <= 1'b1;
            if (c_conf && (cf_cnt < ELEM_CNT))
            begin
              cfm[cf_cnt[1:0]] <= elem_meta;
              cfs[cf_cnt[1:0]] <= elem_mas;
              cf_cnt <= cf_cnt + 3'h1;
            end
          end
          if (bcn_end)
            state <= ST_EVAL;
        end
        ST_EVAL:
        begin
          term_reg <= nb_hit && nb_me[nb_idx] && !me_any;
          if (cf_cnt != 3'h0)
          begin
            nv_reg <= 1'b1;
            sel_conf <= 1'b1;
            rsn_reg <= RSN_CONF;
            len_reg <= cf_cnt;
            ntf_event <= 1'b1;
            state <= ST_CONF;
          end
          else
            state <= ST_DECIDE;
        end
        ST_CONF:
          if (ack_wr)
          begin
            nv_reg <= 1'b0;
            state <= ST_DECIDE;
          end
        ST_DECIDE:
        begin
          sel_conf <= 1'b0;
          if (rx_any)
          begin
            nv_reg <= 1'b1;
            rsn_reg <= RSN_RX;
            len_reg <= rx_cnt;
            ntf_event <= 1'b1;
            state <= ST_WAIT;
          end
          else if (term_reg)
          begin
            nv_reg <= 1'b1;
            rsn_reg <= RSN_TERM;
            len_reg <= 3'h0;
            ntf_event <= 1'b1;
            state <= ST_WAIT;
          end
          else
            state <= ST_IDLE;
        end
        ST_WAIT:
          if (ack_wr)
          begin
            nv_reg <= 1'b0;
            state <= ST_IDLE;
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Neighbour record
  // ----------------------------------------------------------------
  always_comb
  begin
    nb_hit = 1'b0;
    nb_idx = 3'h0;
    nb_free_ok = 1'b0;
    nb_free = 3'h0;
    for (int i = 0; i < NB_N; i++)
    begin
      if (nb_used[i] && (nb_addr[i] == src_reg))
      begin
        nb_hit = 1'b1;
        nb_idx = 3'(i);
      end
      if (!nb_used[i])
      begin
        nb_free_ok = 1'b1;
        nb_free = 3'(i);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      nb_rr <= 3'h0;
      for (int i = 0; i < NB_N; i++)
      begin
        nb_addr[i] <= 16'h0;
        nb_used[i] <= 1'b0;
        nb_me[i] <= 1'b0;
      end
    end
    else if (state == ST_EVAL)
    begin
      if (nb_hit)
        nb_me[nb_idx] <= me_any;
      else if (me_any)
      begin
        nb_addr[nb_free_ok ? nb_free : nb_rr] <= src_reg;
        nb_used[nb_free_ok ? nb_free : nb_rr] <= 1'b1;
        nb_me[nb_free_ok ? nb_free : nb_rr] <= 1'b1;
        if (!nb_free_ok)
          nb_rr <= nb_rr + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Own beacon DRP block
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tx_cnt_reg <= 3'h0;
      tx_pend_reg <= 1'b0;
      tx_sent_reg <= 1'b0;
      result_event_block_valid <= 1'b0;
      done_reg <= 1'b0;
      ovf_reg <= 1'b0;
      for (int i = 0; i < ELEM_N; i++)
      begin
        txa_m[i] <= 17'h0;
        txa_s[i] <= 32'h0;
      end
    end
    else
    begin
      result_event_block_valid <= 1'b0;
      if (bcn_tx_start && tx_pend_reg)
      begin
        txa_m <= txs_m;
        txa_s <= txs_s;
        tx_cnt_reg <= tstage_reg;
        tx_sent_reg <= 1'b1;
      end
      else if (bcn_tx_done && tx_sent_reg)
        tx_sent_reg <= 1'b0;
      tx_pend_reg <= commit || (tx_pend_reg && !bcn_tx_start);
      if (bcn_tx_done && tx_sent_reg && !bcn_tx_start)
        result_event_block_valid <= 1'b1;
      done_reg <= (bcn_tx_done && tx_sent_reg && !bcn_tx_start) ||
                  (done_reg && !(wr_en && (paddr == A_STAT) && pwdata[STAT_DONE]));
      ovf_reg <= drop || (ovf_reg && !(wr_en && (paddr == A_STAT) && pwdata[STAT_OVF]));
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tx_count <= 3'h0;
      tx_rd_tgt <= 16'h0;
      tx_rd_status <= 1'b0;
      tx_rd_mas <= 32'h0;
    end
    else
    begin
      tx_count <= tx_cnt_reg;
      tx_rd_tgt <= txa_m[tx_rd_idx][15:0];
      tx_rd_status <= txa_m[tx_rd_idx][16];
      tx_rd_mas <= txa_s[tx_rd_idx];
    end
  end

  // ----------------------------------------------------------------
  // Command frame forwarding
  // ----------------------------------------------------------------
  // Forward frames addressed to dev_reg, or to mc_reg when CTRL_MC is set, while CTRL_CFF is clear.
  assign cf_hit = cf_valid && !ctrl_reg[CTRL_CFF] &&
                  ((cf_dest == dev_reg) || (ctrl_reg[CTRL_MC] && (cf_dest == mc_reg)));

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cfn_valid <= 1'b0;
      cfn_src <= 16'h0;
      cfn_len <= 8'h0;
    end
    else
    begin
      cfn_valid <= cf_hit;
      if (cf_hit)
      begin
        cfn_src <= cf_src;
        cfn_len <= cf_len;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_rx_go;
    (state == ST_DECIDE) && rx_any;
  endsequence

  a_apb_answer: assert property (s_acc |=> pready) else $error("apb no answer");
  a_rx_single: assert property (s_rx_go |=>
    ntf_event && rsn_reg == RSN_RX ##1 !ntf_event) else $error("rx notice wrong");
  a_rx_fields: assert property (s_rx_go |=>
    len_reg == $past(rx_cnt) && nv_reg) else $error("rx notice fields");
  a_term_empty: assert property ((state == ST_DECIDE && !rx_any && term_reg) |=>
    rsn_reg == RSN_TERM && len_reg == 3'h0 && nv_reg) else $error("bad termination");
  a_remain_rx: assert property ((state == ST_DECIDE && rx_any && term_reg) |=>
    rsn_reg != RSN_TERM) else $error("partial as term");
  a_conf_notice: assert property ((state == ST_EVAL && cf_cnt != 3'h0) |=>
    rsn_reg == RSN_CONF && len_reg == $past(cf_cnt) && sel_conf) else $error("bad conflict");
  a_conf_count: assert property ((state == ST_RECV && elem_valid && c_conf &&
    cf_cnt < ELEM_CNT) |=> cf_cnt == $past(cf_cnt) + 3'h1) else $error("conflict lost");
  a_avail_kept: assert property ((state == ST_RECV && elem_valid &&
    elem_kind == KIND_AVAIL && rx_cnt < ELEM_CNT) |=> rx_cnt == $past(rx_cnt) + 3'h1)
    else $error("avail lost");
  a_mc_gate: assert property ((state == ST_RECV && elem_valid && elem_kind == KIND_DRP &&
    elem_target != dev_reg && !ctrl_reg[CTRL_MC]) |=> $stable(rx_any) && $stable(rx_cnt))
    else $error("mc leak");
  a_term_detect: assert property ((state == ST_EVAL && nb_hit && nb_me[nb_idx] &&
    !me_any) |=> term_reg) else $error("term missed");
  a_nbr_record: assert property ((state == ST_EVAL && me_any) |=>
    nb_hit && nb_me[nb_idx]) else $error("nbr not kept");
  a_cf_forward: assert property ((cf_valid && cf_dest == dev_reg &&
    !ctrl_reg[CTRL_CFF]) |=> cfn_valid && cfn_src == $past(cf_src)) else $error("cf dropped");
  a_cf_filter: assert property ((cf_valid && ctrl_reg[CTRL_CFF]) |=> !cfn_valid)
    else $error("cf not filtered");
  a_tx_insert: assert property ((bcn_tx_start && tx_pend_reg) |=>
    tx_cnt_reg == $past(tstage_reg) ##1 tx_count == $past(tstage_reg, 2))
    else $error("block not inserted");
  a_result_event_block_after: assert property ((bcn_tx_done && tx_sent_reg && !bcn_tx_start) |=>
    result_event_block_valid && done_reg && !tx_sent_reg) else $error("no result event");
endmodule // dbn_top
`default_nettype wire

//--- hdl/dbn_pkg.sv
`default_nettype none
package dbn_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ELEM_N = 4;
  localparam int NB_N = 8;
  localparam logic [2:0] ELEM_CNT = 3'h4;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DEV = 8'h04;
  localparam logic [7:0] A_MCAST = 8'h08;
  localparam logic [7:0] A_NSTAT = 8'h0c;
  localparam logic [7:0] A_NSRC = 8'h10;
  localparam logic [7:0] A_NIDX = 8'h14;
  localparam logic [7:0] A_NTGT = 8'h18;
  localparam logic [7:0] A_NMAS = 8'h1c;
  localparam logic [7:0] A_NACK = 8'h20;
  localparam logic [7:0] A_TIDX = 8'h24;
  localparam logic [7:0] A_TTGT = 8'h28;
  localparam logic [7:0] A_TMAS = 8'h2c;
  localparam logic [7:0] A_TCMD = 8'h30;
  localparam logic [7:0] A_STAT = 8'h34;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_MC = 0;
  localparam int CTRL_CFF = 1;
  localparam int TCMD_COMMIT = 8;
  localparam int STAT_OVF = 0;
  localparam int STAT_DONE = 1;
  localparam int NACK_BIT = 0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Reason codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RSN_RX = 8'h00;
  localparam logic [7:0] RSN_CONF = 8'h02;
  localparam logic [7:0] RSN_TERM = 8'h03;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {KIND_OTHER, KIND_DRP, KIND_AVAIL} dbn_kind_t;
  typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_EVAL, ST_CONF, ST_DECIDE,
                            ST_WAIT} dbn_state_t;
endpackage : dbn_pkg
`default_nettype wire

//--- hdl/dbn_elem_class.sv
`default_nettype none
module dbn_elem_class
  import dbn_pkg::*;
(
  // Element
  input  wire dbn_pkg::dbn_kind_t kind,
  input  wire logic [15:0]        target,
  input  wire logic [31:0]        mas,
  // Local setup
  input  wire logic [15:0]        own_addr,
  input  wire logic [15:0]        mc_addr,
  input  wire logic               mc_en,
  input  wire logic [31:0]        own_mask,
  // Verdict
  output logic                    to_me,
  output logic                    keep_drp,
  output logic                    keep_rx,
  output logic                    conflict
);
  logic is_drp;
  assign is_drp = (kind == KIND_DRP);
  assign to_me = is_drp && (target == own_addr);
  assign keep_drp = to_me || (is_drp && mc_en && (target == mc_addr));
  assign keep_rx = keep_drp || (kind == KIND_AVAIL);
  assign conflict = is_drp && (target != own_addr) && ((mas & own_mask) != 32'h0);
endmodule // dbn_elem_class
`default_nettype wire

//--- sim/dbn_peer.sv
`default_nettype none
module dbn_peer
  import dbn_pkg::*;
(
  // Clock
  input  wire logic            sys_clk,
  // Beacon from a neighbour
  output logic                 bcn_start,
  output logic [15:0]          bcn_src,
  output logic [7:0]           bcn_slot,
  output logic                 elem_valid,
  output var dbn_pkg::dbn_kind_t elem_kind,
  output logic [15:0]          elem_target,
  output logic                 elem_status,
  output logic [31:0]          elem_mas,
  output logic                 bcn_end,
  // Command frame from a neighbour
  output logic                 cf_valid,
  output logic [15:0]          cf_src,
  output logic [15:0]          cf_dest,
  output logic [7:0]           cf_len
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {bcn_start, elem_valid, bcn_end, cf_valid} = '0;
    {bcn_src, bcn_slot, elem_target, elem_status, elem_mas, cf_src, cf_dest, cf_len} = '0;
    elem_kind = KIND_OTHER;
  end

  // Sends one beacon with one element and an optional availability element.
  task automatic send(input logic [15:0] s, input logic [7:0] sl, input dbn_kind_t k,
                      input logic [15:0] t, input logic [31:0] m, input logic av);
    @(posedge sys_clk);
    bcn_start <= 1'b1;
    bcn_src <= s;
    bcn_slot <= sl;
    @(posedge sys_clk);
    bcn_start <= 1'b0;
    bcn_src <= ~s;
    elem_valid <= 1'b1;
    elem_kind <= k;
    elem_target <= t;
    elem_mas <= m;
    if (av)
    begin
      @(posedge sys_clk);
      elem_kind <= KIND_AVAIL;
      elem_mas <= ~m;
    end
    @(posedge sys_clk);
    elem_valid <= 1'b0;
    bcn_end <= 1'b1;
    elem_target <= ~t;
    elem_mas <= ~m;
    @(posedge sys_clk);
    bcn_end <= 1'b0;
  endtask

  // Sends one command frame; released source and destination are scrambled.
  task automatic frame(input logic [15:0] s, input logic [15:0] d, input logic [7:0] n);
    @(posedge sys_clk);
    cf_valid <= 1'b1;
    cf_src <= s;
    cf_dest <= d;
    cf_len <= n;
    @(posedge sys_clk);
    cf_valid <= 1'b0;
    cf_src <= ~s;
    cf_dest <= ~d;
  endtask
endmodule // dbn_peer
`default_nettype wire

//--- sim/dbn_top_test.sv
`default_nettype none
module dbn_top_test import dbn_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, bcn_slot, cf_len, cfn_len;
  logic [31:0] pwdata, prdata, rdat, elem_mas, tx_rd_mas;
  logic bcn_start, elem_valid, elem_status, bcn_end, cf_valid, cfn_valid, ntf_event;
  logic ntf_busy, bcn_tx_start, bcn_tx_done, tx_rd_status, result_event_block_valid;
  logic [15:0] bcn_src, elem_target, cf_src, cf_dest, cfn_src, tx_rd_tgt;
  logic [2:0] tx_count;
  dbn_kind_t elem_kind;
  int failures, samples_checked, events, rcebs, cfns;

  dbn_top i_dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bcn_start, .bcn_src, .bcn_slot, .elem_valid, .elem_kind,
    .elem_target, .elem_status, .elem_mas, .bcn_end, .cf_valid, .cf_src, .cf_dest, .cf_len,
    .cfn_valid, .cfn_src, .cfn_len, .ntf_event, .ntf_busy, .bcn_tx_start, .bcn_tx_done,
    .tx_rd_idx(2'h0), .tx_count, .tx_rd_tgt, .tx_rd_status, .tx_rd_mas, .result_event_block_valid);
  dbn_peer i_peer (.sys_clk, .bcn_start, .bcn_src, .bcn_slot, .elem_valid, .elem_kind,
    .elem_target, .elem_status, .elem_mas, .bcn_end, .cf_valid, .cf_src, .cf_dest, .cf_len);

  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    events <= events + int'(ntf_event === 1'b1);
    rcebs <= rcebs + int'(result_event_block_valid === 1'b1);
    cfns <= cfns + int'(cfn_valid === 1'b1);
  end

  task test_done();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      chk("pready timeout", 1, 0);
      test_done();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask

  task note(input logic [31:0] st, input logic [31:0] m, input logic [15:0] src, int ev);
    int n;
    n = 0;
    while (ntf_busy !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20)
    begin
      chk("busy timeout", 1, 0);
      test_done();
    end
    rd(A_NSTAT, st, m, "nstat");
    rd(A_NSRC, {16'h0, src}, 32'hffff, "nsrc");
    chk("events", ev, events);
    wr(A_NACK, 32'h1);
    repeat (3) @(posedge sys_clk);
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, bcn_tx_start, bcn_tx_done} = '0;
    reset = 1'b1;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rd(A_CTRL, 32'h0, 32'hffffffff, "ctrl");
    rd(8'h3c, 32'h0, 32'hffffffff, "unmapped");
    chk("slverr", 1, rerr);
    wr(A_DEV, 32'h0011);
    $display("test registers done");
    i_peer.send(16'h0022, 8'h05, KIND_DRP, 16'h0011, 32'h3, 1'b1);
    note(32'h0005_8200, 32'hffffffff, 16'h0022, 1);
    rd(A_NMAS, 32'h3, 32'hffffffff, "nmas");
    rd(A_NTGT, 32'h0002_0011, 32'hffffffff, "ntgt");
    wr(A_NIDX, 32'h1);
    rd(A_NMAS, 32'hffff_fffc, 32'hffffffff, "nmas avail");
    i_peer.send(16'h0022, 8'h06, KIND_DRP, 16'h0011, 32'h1, 1'b0);
    note(32'h0006_8100, 32'hffffffff, 16'h0022, 2);
    i_peer.send(16'h0022, 8'h07, KIND_OTHER, 16'h0011, 32'h1, 1'b0);
    note(32'h0000_8003, 32'h0000_87ff, 16'h0022, 3);
    $display("test receive done");
    wr(A_TTGT, 32'h1_0022);
    wr(A_TMAS, 32'hf0);
    wr(A_TCMD, 32'h101);
    @(posedge sys_clk);
    bcn_tx_start <= 1'b1;
    @(posedge sys_clk);
    bcn_tx_start <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("tx count", 1, tx_count);
    chk("tx mas", 32'hf0, tx_rd_mas);
    chk("tx tgt", 32'h22, tx_rd_tgt);
    chk("tx status", 1, tx_rd_status);
    chk("result_event_block early", 0, rcebs);
    bcn_tx_done <= 1'b1;
    @(posedge sys_clk);
    bcn_tx_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("result_event_block", 1, rcebs);
    rd(A_STAT, 32'h2, 32'h2, "stat done");
    wr(A_STAT, 32'h2);
    rd(A_STAT, 32'h0, 32'h2, "stat clear");
    i_peer.send(16'h0044, 8'h09, KIND_DRP, 16'h0055, 32'h10, 1'b0);
    note(32'h0009_8102, 32'hffffffff, 16'h0044, 4);
    chk("busy", 0, ntf_busy);
    $display("test conflict done");
    i_peer.frame(16'h0022, 16'h0011, 8'h10);
    repeat (2) @(posedge sys_clk);
    chk("cfn src", 32'h22, cfn_src);
    chk("cfn len", 32'h10, cfn_len);
    wr(A_CTRL, 32'h1);
    wr(A_MCAST, 32'h0ff0);
    i_peer.send(16'h0022, 8'h01, KIND_DRP, 16'h0011, 32'h100, 1'b0);
    note(32'h0001_8100, 32'hffffffff, 16'h0022, 5);
    i_peer.send(16'h0022, 8'h02, KIND_DRP, 16'h0ff0, 32'h100, 1'b0);
    note(32'h0002_8100, 32'hffffffff, 16'h0022, 6);
    i_peer.frame(16'h0066, 16'h0ff0, 8'h04);
    wr(A_CTRL, 32'h3);
    i_peer.frame(16'h0022, 16'h0011, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("cfn count", 2, cfns);
    $display("test frames done");
    test_done();
  end
endmodule // dbn_top_test
`default_nettype wire
